// file: src/wss_pkg.sv
// Package: timing counts, field thresholds and state types of the
// wheel speed output core.
// Assumes a 10 MHz core clock and a signed 12-bit field sample.
package wss_pkg;
    localparam int CLK_MHZ     = 10;           // Core clock rate
    localparam int FIELD_W     = 12;           // Field sample width
    localparam int CNT_W       = 24;           // Timer width
    // Minimum field threshold in sample units
    localparam int FIELD_LIMIT = 80;
    localparam int WARN_MULT   = 2;            // Warning field = 2 x limit
    localparam int EL_MULT     = 4;            // Mounting range = 4 x limit
    // Times as specified
    localparam int T_ON_US       = 200;
    localparam int PRE_LOW_US    = 45;
    localparam int WARN_US       = 45;
    localparam int LEFT_US       = 90;
    localparam int RIGHT_US      = 180;
    localparam int LEFT_EL_US    = 360;
    localparam int RIGHT_EL_US   = 720;
    localparam int STOP_PULSE_US = 1400;       // 1.4 ms
    localparam int T_STOP_MS     = 737;
    localparam int EL_FMAX_HZ    = 117;
    // Derived cycle counts
    localparam int T_ON_CYC      = T_ON_US * CLK_MHZ;
    localparam int PRE_LOW_CYC   = PRE_LOW_US * CLK_MHZ;
    localparam int WARN_CYC      = WARN_US * CLK_MHZ;
    localparam int LEFT_CYC      = LEFT_US * CLK_MHZ;
    localparam int RIGHT_CYC     = RIGHT_US * CLK_MHZ;
    localparam int LEFT_EL_CYC   = LEFT_EL_US * CLK_MHZ;
    localparam int RIGHT_EL_CYC  = RIGHT_EL_US * CLK_MHZ;
    localparam int STOP_CYC      = STOP_PULSE_US * CLK_MHZ;
    localparam int T_STOP_CYC    = T_STOP_MS * 1000 * CLK_MHZ;
    // Half magnetic period at the highest mounting-range frequency
    localparam int EL_GAP_CYC    = (CLK_MHZ * 1000000) / (2 * EL_FMAX_HZ);
    // Clock monitor: reference tick period and quarter-rate floor
    localparam int REF_TICK_CYC  = 1000;
    localparam int CLK_MIN_CYC   = REF_TICK_CYC / 4;
    localparam int SLOW_SHIFT    = 3;          // Calibrated loop gain 1/8

    typedef enum logic [1:0] {M_POWER_ON, M_UNCAL, M_CAL} mode_e;
    typedef enum logic [1:0] {P_IDLE, P_PRE, P_HIGH} phase_e;
endpackage

// file: src/sync_bit.sv
// Two-flop synchroniser for a level from outside the clock domain.
// Assumes the caller reads only syncOut.
`timescale 1ns/1ns
module sync_bit (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic clkEn,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1_reg;

    // First stage feeds only the second
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= 1'b0;
            syncOut    <= 1'b0;
        end else if (clkEn) begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end
endmodule

// file: src/wheel_speed_core.sv
// Wheel speed output core: offset tracking, mode control, pulse coding
// and safety reactions driving the two-level current interface.
// Assumes field samples, direction events and monitor flags arrive on
// sys_clk; supply status and the clock reference tick are asynchronous.
`timescale 1ns/1ns
// Behaviour
// - Uncalibrated first pulse fires once field exceeds twice the threshold.
// - Threshold start puts the first pulse on the first pole pair.
// - After min, max and offset found, switch at each zero crossing.
// - First uncalibrated pulse is a warning pulse, still a speed edge.
// - After power-on time, track input in uncalibrated mode, fast offset.
// - Two modes only; move to calibrated once offset is compensated.
// - Calibrated mode ignores signals below the minimum field threshold.
// - Calibrated mode uses a slower offset loop.
// - Undervoltage forces failure current regardless of field.
// - Supply back above release restarts from power-on.
// - During power-on output never goes to high current.
// - Internal error shows as constant failure current or warning flag.
// - Safety mechanism at standstill: standstill pulses, warning suppressed.
// - From next speed event after standstill, warn while failure lasts.
// - Undervoltage error persists until supply is normal again.
// - Fuse count mismatch latches failure current until power cycle.
// - Stuck or quarter-rate clock enters failure indication (code flags only under CLK_MIN_CYC cycles between reference ticks).
// - Over two speed events without direction event, or reverse, faults.
// - Critical air gap, clipping and temperature count as safety states.
// - Pulse widths: warning 45 us, left 90 us, right 180 us.
// - Low current for 45 us between transition and pulse rise.
// - No signal for 737 ms emits a 1.4 ms standstill pulse.
// - Weak field below 117 Hz: left 360 us, right 720 us.
module wheel_speed_core
    import wss_pkg::*;
#(
    parameter logic [CNT_W-1:0] RIGHT_EL_LEN = CNT_W'(RIGHT_EL_CYC),
    parameter logic [CNT_W-1:0] STOP_LEN     = CNT_W'(STOP_CYC),
    parameter logic [CNT_W-1:0] STANDSTILL   = CNT_W'(T_STOP_CYC),
    parameter logic [CNT_W-1:0] EL_GAP       = CNT_W'(EL_GAP_CYC)
) (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               clkEn,
    input  wire logic signed [11:0] fieldSample,
    input  wire logic               sampleValid,
    input  wire logic               dirEvent,
    input  wire logic               dirLeft,
    input  wire logic               supplyOk,
    input  wire logic               refTick,
    input  wire logic [7:0]         fuseCount,
    input  wire logic [7:0]         fuseStored,
    input  wire logic               airgapCritical,
    input  wire logic               adcClipping,
    input  wire logic               overTemp,
    output logic                    currHigh,
    output logic                    currError
);
    typedef struct packed {
        mode_e                    mode;
        phase_e                   phase;
        logic [CNT_W-1:0]         phCnt;
        logic [CNT_W-1:0]         hiLen;
        logic [CNT_W-1:0]         onCnt;
        logic [CNT_W-1:0]         idleCnt;
        logic [CNT_W-1:0]         gapCnt;
        logic [CNT_W-1:0]         refCnt;
        logic signed [FIELD_W:0]  offset;
        logic signed [FIELD_W:0]  minVal;
        logic signed [FIELD_W:0]  maxVal;
        logic [FIELD_W:0]         peak;
        logic                     sawMin;
        logic                     sawMax;
        logic                     outSign;
        logic                     armed;
        logic                     firstDone;
        logic                     dirKnown;
        logic                     dirIsLeft;
        logic [1:0]               speedRun;
        logic [1:0]               dirRun;
        logic                     discrepancy;
        logic                     fuseFail;
        logic                     clkFail;
        logic                     standstill;
        logic                     isWarn;
        logic                     refPrev;
        logic                     currHigh;
        logic                     currError;
    } st_s;

    // Reference count starts full: no earlier tick to measure against
    localparam st_s ST_INIT = '{mode: M_POWER_ON, phase: P_IDLE,
        refCnt: '1, currError: 1'b1, default: '0};
    localparam logic [FIELD_W:0] LIM  = (FIELD_W+1)'(FIELD_LIMIT);
    localparam logic [FIELD_W:0] WLIM = (FIELD_W+1)'(WARN_MULT*FIELD_LIMIT);
    localparam logic [FIELD_W:0] ELIM = (FIELD_W+1)'(EL_MULT*FIELD_LIMIT);

    st_s st_reg;
    st_s st_next;

    logic                    supplyOkSync;
    logic                    refSync;
    logic signed [FIELD_W:0] corr;
    logic [FIELD_W:0]        absCorr;
    logic                    newSign;
    logic                    speedEvent;
    logic                    smActive;
    logic                    underVolt;

    // Asynchronous pins pass two flip-flops
    sync_bit u_supply_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clkEn   (clkEn),
        .asyncIn (supplyOk),
        .syncOut (supplyOkSync)
    );
    sync_bit u_ref_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clkEn   (clkEn),
        .asyncIn (refTick),
        .syncOut (refSync)
    );

    // Saturating timer step
    function automatic logic [CNT_W-1:0] incSat(input logic [CNT_W-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction

    // Magnitude of a signed field value
    function automatic logic [FIELD_W:0] magOf(
        input logic signed [FIELD_W:0] v);
        return v[FIELD_W] ? (FIELD_W+1)'(-v) : v;
    endfunction

    // Offset-corrected field and its magnitude
    assign corr    = (FIELD_W+1)'(fieldSample) - st_reg.offset;
    assign absCorr = magOf(corr);
    assign newSign = corr[FIELD_W];
    assign underVolt = !supplyOkSync;
    assign smActive  = st_reg.discrepancy | airgapCritical
        | adcClipping | overTemp;

    // Next-state logic
    always_comb begin
        logic signed [FIELD_W:0] mid;
        logic                    kindWarn;
        st_next    = st_reg;
        speedEvent = 1'b0;
        mid        = (st_reg.minVal + st_reg.maxVal) >>> 1;
        kindWarn   = 1'b0;
        // Latched safety faults
        if (fuseCount != fuseStored) begin
            st_next.fuseFail = 1'b1;
        end
        st_next.refPrev = refSync;
        st_next.refCnt  = incSat(st_reg.refCnt);
        if (refSync && !st_reg.refPrev) begin
            if (st_reg.refCnt < CNT_W'(CLK_MIN_CYC)) begin
                st_next.clkFail = 1'b1;
            end
            st_next.refCnt = '0;
        end
        if (dirEvent) begin
            st_next.dirKnown  = 1'b1;
            st_next.dirIsLeft = dirLeft;
            st_next.speedRun  = 2'h0;
            st_next.dirRun    = (st_reg.dirRun == 2'h3) ? 2'h3
                                : st_reg.dirRun + 2'h1;
        end
        unique case (st_reg.mode)
            M_POWER_ON: begin
                st_next.onCnt = incSat(st_reg.onCnt);
                if (st_reg.onCnt >= CNT_W'(T_ON_CYC - 1)) begin
                    st_next.mode = M_UNCAL;
                end
            end
            M_UNCAL, M_CAL: begin
                st_next.gapCnt  = incSat(st_reg.gapCnt);
                st_next.idleCnt = incSat(st_reg.idleCnt);
                if (sampleValid) begin
                    // Extreme tracking, restarted on entry to a half-wave
                    if (newSign && (!st_reg.outSign
                        || (FIELD_W+1)'(fieldSample) < st_reg.minVal)) begin
                        st_next.minVal = (FIELD_W+1)'(fieldSample);
                    end
                    if (!newSign && (st_reg.outSign
                        || (FIELD_W+1)'(fieldSample) > st_reg.maxVal)) begin
                        st_next.maxVal = (FIELD_W+1)'(fieldSample);
                    end
                    if (absCorr > st_reg.peak) begin
                        st_next.peak = absCorr;
                    end
                    if (!st_reg.firstDone && absCorr > WLIM) begin
                        speedEvent        = 1'b1;
                        st_next.firstDone = 1'b1;
                        st_next.outSign   = newSign;
                        st_next.armed     = 1'b1;
                    end else if (st_reg.armed
                                 && newSign != st_reg.outSign) begin
                        speedEvent      = 1'b1;
                        st_next.outSign = newSign;
                        st_next.armed   = 1'b0;
                        st_next.peak    = '0;
                        st_next.sawMax  = st_reg.sawMax | !st_reg.outSign;
                        st_next.sawMin  = st_reg.sawMin | st_reg.outSign;
                    end else if (st_reg.firstDone
                                 && newSign == st_reg.outSign
                                 && absCorr > ((st_reg.mode == M_CAL)
                                    ? LIM : WLIM)) begin
                        st_next.armed = 1'b1;
                    end
                end
                if (speedEvent && st_reg.sawMin && st_reg.sawMax) begin
                    if (st_reg.mode == M_UNCAL) begin
                        st_next.offset = mid;
                        st_next.mode   = M_CAL;
                    end else begin
                        st_next.offset = st_reg.offset
                            + ((mid - st_reg.offset) >>> SLOW_SHIFT);
                    end
                    st_next.sawMin = 1'b0;
                    st_next.sawMax = 1'b0;
                end
            end
            default: st_next.mode = M_POWER_ON;
        endcase
        // Speed/direction discrepancy watch
        if (speedEvent) begin
            st_next.dirRun   = 2'h0;
            st_next.speedRun = (st_reg.speedRun == 2'h3) ? 2'h3
                               : st_reg.speedRun + 2'h1;
        end
        if (st_reg.speedRun == 2'h3 || st_reg.dirRun == 2'h3) begin
            st_next.discrepancy = 1'b1;
        end
        // Pulse coding at a speed event
        if (speedEvent) begin
            // Judge the peak of the half-wave that just ended
            kindWarn = !st_reg.dirKnown || !st_reg.firstDone
                || smActive || st_reg.peak < WLIM;
            st_next.isWarn     = kindWarn;
            st_next.standstill = 1'b0;
            st_next.idleCnt    = '0;
            st_next.gapCnt     = '0;
            st_next.phase      = P_PRE;
            st_next.phCnt      = '0;
            if (kindWarn) begin
                st_next.hiLen = CNT_W'(WARN_CYC);
            end else if (st_reg.peak < ELIM
                         && st_reg.gapCnt >= EL_GAP) begin
                st_next.hiLen = st_reg.dirIsLeft
                    ? CNT_W'(LEFT_EL_CYC) : RIGHT_EL_LEN;
            end else begin
                st_next.hiLen = st_reg.dirIsLeft
                    ? CNT_W'(LEFT_CYC) : CNT_W'(RIGHT_CYC);
            end
        end else if (st_reg.mode != M_POWER_ON
                     && st_reg.idleCnt >= STANDSTILL - 1'b1) begin
            st_next.standstill = 1'b1;
            st_next.isWarn     = 1'b0;
            st_next.idleCnt    = '0;
            st_next.phase      = P_PRE;
            st_next.phCnt      = '0;
            st_next.hiLen      = STOP_LEN;
        end else begin
            // Pre-low then high phase timing
            st_next.phCnt = incSat(st_reg.phCnt);
            unique case (st_reg.phase)
                P_IDLE: st_next.phCnt = '0;
                P_PRE: begin
                    if (st_reg.phCnt >= CNT_W'(PRE_LOW_CYC - 1)) begin
                        st_next.phase = P_HIGH;
                        st_next.phCnt = '0;
                    end
                end
                P_HIGH: begin
                    if (st_reg.phCnt >= st_reg.hiLen - 1'b1) begin
                        st_next.phase = P_IDLE;
                        st_next.phCnt = '0;
                    end
                end
                default: st_next.phase = P_IDLE;
            endcase
        end
        // Undervoltage restarts from power-on, keeping the fuse and clock faults
        if (underVolt) begin
            st_next          = ST_INIT;
            st_next.fuseFail = st_reg.fuseFail;
            st_next.clkFail  = st_reg.clkFail;
            st_next.refCnt   = st_reg.refCnt;
            st_next.refPrev  = refSync;
        end
        // Output current levels, failure level dominant
        st_next.currError = underVolt | st_next.fuseFail
            | st_next.clkFail;
        st_next.currHigh  = !st_next.currError
            && st_next.mode != M_POWER_ON
            && st_next.phase == P_HIGH;
    end

    // State register, frozen while clkEn is low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg <= ST_INIT;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    assign currHigh  = st_reg.currHigh;
    assign currError = st_reg.currError;

    // Checks on the pulse coding and safety reactions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || !clkEn);

    a_undervolt_fail: assert property (underVolt |=> currError && !currHigh)
        else $error("undervoltage did not force failure current");
    a_poweron_low: assert property (st_reg.mode == M_POWER_ON |-> !currHigh)
        else $error("high current during power-on");
    a_prelow_hold: assert property (speedEvent && !underVolt
        |=> (st_reg.phase == P_PRE && !currHigh) [*8])
        else $error("pre-low phase too short");
    a_fuse_sticky: assert property (st_reg.fuseFail |=> currError)
        else $error("fuse mismatch not latched");
    a_first_warn: assert property (speedEvent && !st_reg.firstDone
        |=> st_reg.hiLen == CNT_W'(WARN_CYC))
        else $error("first pulse not a warning pulse");
    a_cal_armed: assert property (speedEvent && st_reg.mode == M_CAL
        |-> st_reg.armed)
        else $error("switching without threshold crossing");
    a_disc_flag: assert property (st_reg.speedRun == 2'h3 && !underVolt
        |=> st_reg.discrepancy)
        else $error("speed/direction discrepancy not flagged");
    a_clk_fail: assert property (refSync && !st_reg.refPrev
        && st_reg.refCnt < CNT_W'(CLK_MIN_CYC) |=> ##1 currError)
        else $error("slow clock not indicated");
    a_stop_nowarn: assert property (st_reg.standstill |-> !st_reg.isWarn)
        else $error("warning shown on standstill pulse");
    a_warn_sm: assert property (speedEvent && smActive && !underVolt
        |=> st_reg.hiLen == CNT_W'(WARN_CYC))
        else $error("active safety state without warning");
    a_pulse_width: assert property ($rose(st_reg.phase == P_HIGH)
        && st_reg.hiLen == CNT_W'(WARN_CYC) && !underVolt
        |-> (st_reg.phase == P_HIGH) [*8])
        else $error("warning pulse ended early");

    c_first_pulse: cover property (speedEvent && st_reg.mode == M_UNCAL);
    c_calibrated: cover property ($rose(st_reg.mode == M_CAL));
    c_standstill: cover property ($rose(st_reg.standstill));
    c_fail_level: cover property ($rose(currError));
endmodule

// file: bench/vcu_model.sv
// Control unit model: reads the two-level current line of the core.
// Assumes currHigh and currError are registered on sys_clk.
`timescale 1ns/1ns
module vcu_model (
    input  wire logic sys_clk,
    input  wire logic currHigh,
    input  wire logic currError,
    output int        pulseCount,
    output int        lastLen,
    output int        levelClash
);
    int run = 0;

    // Measure each high-current pulse in clock cycles
    always @(posedge sys_clk) begin
        if (currHigh === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            pulseCount <= pulseCount + 1;
            lastLen    <= run;
            run        <= 0;
        end
        // High current while failure level is shown is illegal
        if (currHigh === 1'b1 && currError !== 1'b0) begin
            levelClash <= levelClash + 1;
        end
    end
endmodule

// file: bench/tb.sv
// Testbench of the wheel speed output core: field waves, safety flags,
// supply loss and latched faults, judged through the control unit model.
// Assumes shortened standstill, stop and weak-pulse parameters.
`timescale 1ns/1ns
module tb;
    import wss_pkg::*;
    localparam int STOP_T  = 60;
    localparam int STILL_T = 12800;
    localparam int HOLD    = 4100;
    logic               sys_clk, rst, clkEn, sampleValid, dirEvent, dirLeft;
    logic               supplyOk, refTick, airgapCritical, adcClipping;
    logic               overTemp, currHigh, currError;
    logic               fastTick = 1'b0;
    logic signed [11:0] fieldSample;
    logic [7:0]         fuseCount, fuseStored;
    int                 pulseCount, lastLen, levelClash;
    int                 n_errors, checked, cycles;

    wheel_speed_core #(.RIGHT_EL_LEN(24'h28), .STOP_LEN(24'h3C),
        .STANDSTILL(24'h3200), .EL_GAP(24'hC8)) uut (
        .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
        .fieldSample(fieldSample), .sampleValid(sampleValid),
        .dirEvent(dirEvent), .dirLeft(dirLeft), .supplyOk(supplyOk),
        .refTick(refTick), .fuseCount(fuseCount), .fuseStored(fuseStored),
        .airgapCritical(airgapCritical), .adcClipping(adcClipping),
        .overTemp(overTemp), .currHigh(currHigh), .currError(currError));
    vcu_model partner (.sys_clk(sys_clk), .currHigh(currHigh),
        .currError(currError), .pulseCount(pulseCount),
        .lastLen(lastLen), .levelClash(levelClash));

    // Clock and reference tick
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        refTick = 1'b0;
        forever begin
            repeat (fastTick ? 100 : 1000) @(negedge sys_clk);
            refTick = 1'b1;
            @(negedge sys_clk);
            refTick = 1'b0;
        end
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 100000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic reset_dut();
        @(negedge sys_clk);
        rst = 1'b1;
        wait_cyc(2);
        rst = 1'b0;
    endtask
    // One half-wave; exp 0 means no pulse, negative means neither count nor length is checked
    task automatic wave(input int v, input logic left, input logic dir,
                        input int exp);
        int c0;
        c0 = pulseCount;
        // Direction event lands one cycle ahead of the crossing
        @(negedge sys_clk);
        dirEvent = dir;
        dirLeft = left;
        @(negedge sys_clk);
        dirEvent = 1'b0;
        fieldSample = 12'(v);
        wait_cyc(HOLD);
        if (exp >= 0) check("pulse count", c0 + (exp > 0), pulseCount);
        if (exp > 0) check("pulse length", exp, lastLen);
    endtask
    task automatic scen_startup();
        int n;
        int c0;
        n = 0;
        c0 = pulseCount;
        fieldSample = 12'h000;
        wait_cyc(T_ON_CYC + 100);
        check("error level", 0, currError);
        check("pulse count", c0, pulseCount);
        fieldSample = 12'h064;
        wait_cyc(1000);
        check("pulse count", c0, pulseCount);
        fieldSample = 12'h0C8;
        while (currHigh !== 1'b1 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        check("pre-low", PRE_LOW_CYC + 1, n);
        wait_cyc(600);
        check("pulse count", c0 + 1, pulseCount);
        check("first pulse", WARN_CYC, lastLen);
    endtask
    task automatic scen_modes();
        wave(-400, 1'b1, 1'b1, LEFT_EL_CYC);
        wave(400, 1'b1, 1'b1, LEFT_CYC);
        wave(-400, 1'b0, 1'b1, RIGHT_CYC);
        wave(40, 1'b0, 1'b1, RIGHT_CYC);
        wave(-40, 1'b0, 1'b0, 0);
        wave(120, 1'b0, 1'b0, 0);
        wave(-120, 1'b1, 1'b1, WARN_CYC);
    endtask
    task automatic scen_safety();
        for (int i = 0; i < 3; i++) begin
            {overTemp, adcClipping, airgapCritical} = 3'h1 << i;
            wave((i % 2) ? -400 : 400, 1'b1, 1'b1, WARN_CYC);
        end
        {overTemp, adcClipping, airgapCritical} = 3'h0;
    endtask
    task automatic scen_discrepancy();
        int c0;
        wave(-400, 1'b1, 1'b0, -1);
        wave(400, 1'b1, 1'b0, -1);
        wave(-400, 1'b1, 1'b0, -1);
        wave(400, 1'b1, 1'b1, WARN_CYC);
        c0 = pulseCount;
        wait_cyc(STILL_T - HOLD + 600);
        check("stop count", c0 + 1, pulseCount);
        check("stop length", STOP_T, lastLen);
        wave(-400, 1'b1, 1'b1, WARN_CYC);
    endtask
    task automatic scen_supply();
        int c0;
        c0 = pulseCount;
        clkEn = 1'b0;
        supplyOk = 1'b0;
        wait_cyc(6);
        check("frozen level", 0, currError);
        clkEn = 1'b1;
        wait_cyc(6);
        check("error level", 1, currError);
        fieldSample = 12'h190;
        wait_cyc(1000);
        check("pulse count", c0, pulseCount);
        check("error level", 1, currError);
        supplyOk = 1'b1;
        wait_cyc(6);
        check("error level", 0, currError);
        scen_startup();
        wave(-400, 1'b1, 1'b1, LEFT_EL_CYC);
    endtask
    task automatic scen_latches();
        fuseCount = 8'hA5;
        wait_cyc(10);
        fuseCount = 8'h5A;
        wait_cyc(100);
        check("fuse latch", 1, currError);
        reset_dut();
        wait_cyc(10);
        check("error level", 0, currError);
        fastTick = 1'b1;
        wait_cyc(2300);
        check("clock latch", 1, currError);
        fastTick = 1'b0;
        wait_cyc(1100);
        check("clock latch", 1, currError);
        check("level clash", 0, levelClash);
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        sampleValid = 1'b1;
        dirEvent = 1'b0;
        dirLeft = 1'b0;
        supplyOk = 1'b1;
        {overTemp, adcClipping, airgapCritical} = 3'h0;
        fieldSample = 12'h000;
        fuseCount = 8'h5A;
        fuseStored = 8'h5A;
        reset_dut();
        scen_startup();
        scen_modes();
        scen_safety();
        scen_discrepancy();
        scen_supply();
        scen_latches();
        finish_test();
    end
endmodule
